// ==== common/sfpic_defs.vh ====
// Function
// - Only the sleep command B9H puts the device to sleep; deselect means standby.
// - While asleep every command is ignored except the wake command ABH.
// - Sleep runs only if chip select rises right after the eighth command bit.
// - Sleep state is reached after the sleep entry delay from chip select rise.
// - Sleep command during a program, erase or status write cycle is rejected.
// - Chip select high with no cycle running deselects the device into standby.
// - Wake is ABH alone; other commands accepted only after the plain wake delay.
// - ABH with three dummy bytes streams device ID MSB first on falling edges.
// - Wake/ID command is ignored while the operation active flag is 1.
// - 90H with address 0 gives maker then device ID; address 1 swaps order.
// - 9FH streams maker ID, memory type, capacity on falling clock edges.
// - 9FH is not decoded during an erase or program cycle.
// - Chip select high ends ID output and returns the device to standby.
// - A3H plus three dummy bytes enters boost mode.
// - ABH, 06H or B9H leave boost mode.
// - Continuous mode bits AXH make the next transaction the same fast read.
// - In continuous mode standard commands are ignored; FFH clears that mode.
// - Pause 75H acts only during sector/block erase or page program, within limit.
// - While paused, status write, page program and all erases are refused.
// - Busy reads 1 during the pause transition and 0 once reads are allowed.
// - Resume 7AH sets busy and continues the operation; ignored unless paused.
// - Operation active flag is 1 during a self-timed cycle, 0 after it.
`ifndef SFPIC_DEFS_VH
`define SFPIC_DEFS_VH

// Command codes
`define SFPIC_CMD_SLEEP 8'hB9
`define SFPIC_CMD_WAKE_ID 8'hAB
`define SFPIC_CMD_MAKER_PART 8'h90
`define SFPIC_CMD_THREE_ID 8'h9F
`define SFPIC_CMD_BOOST 8'hA3
`define SFPIC_CMD_XIP_EXIT 8'hFF
`define SFPIC_CMD_PAUSE 8'h75
`define SFPIC_CMD_RESUME 8'h7A
`define SFPIC_CMD_WREN 8'h06
`define SFPIC_CMD_WRSR 8'h01
`define SFPIC_CMD_PROG 8'h02
`define SFPIC_CMD_ERASE_SEC 8'h20
`define SFPIC_CMD_ERASE_32K 8'h52
`define SFPIC_CMD_ERASE_64K 8'hD8
`define SFPIC_CMD_ERASE_CH0 8'hC7
`define SFPIC_CMD_ERASE_CH1 8'h60

// Continuous mode match on upper nibble; 90H address that puts device ID first
`define SFPIC_XIP_NIB 4'hA
`define SFPIC_ADDR_DEV_FIRST 8'h01

// Timing, in ns, and clock rate in MHz
`define SFPIC_CLK_MHZ 250
`define SFPIC_SLEEP_NS 3000
`define SFPIC_WAKE1_NS 3000
`define SFPIC_WAKE2_NS 1800
`define SFPIC_PAUSE_NS 2000

// Identification values (arbitrary)
`define SFPIC_MFR_ID 8'h5A
`define SFPIC_MEM_TYPE 8'h40
`define SFPIC_MEM_CAP 8'h13
`define SFPIC_DEV_ID 8'h12

// Output stream lengths in bits, and index of the last dummy byte
`define SFPIC_LEN8 5'd8
`define SFPIC_LEN16 5'd16
`define SFPIC_LEN24 5'd24
`define SFPIC_DUMMY_LAST 2'd2

// Pin idle levels after reset: chip select high, clock and data low
`define SFPIC_PIN_IDLE 3'h4

`endif

// ==== design/sfpic_core.v ====
`include "sfpic_defs.vh"

module sfpic_core #(
    parameter SLEEP_NS = `SFPIC_SLEEP_NS,
    parameter WAKE1_NS = `SFPIC_WAKE1_NS,
    parameter WAKE2_NS = `SFPIC_WAKE2_NS,
    parameter PAUSE_NS = `SFPIC_PAUSE_NS,
    parameter [7:0] MFR_ID = `SFPIC_MFR_ID,
    parameter [7:0] MEM_TYPE = `SFPIC_MEM_TYPE,
    parameter [7:0] MEM_CAP = `SFPIC_MEM_CAP,
    parameter [7:0] DEV_ID = `SFPIC_DEV_ID
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire en_i,
    input wire cs_n_i,
    input wire sclk_i,
    input wire si_i,
    output wire so_o,
    output wire so_oe_o,
    input wire op_active_flag_i,
    input wire op_pausable_i,
    input wire cont_bits_valid_i,
    input wire [7:0] continuous_mode_bits_i,
    output reg cmd_valid_o,
    output reg [7:0] cmd_code_o,
    output reg xip_read_o,
    output reg op_pause_o,
    output reg op_resume_o,
    output reg busy_o,
    output reg asleep_o,
    output wire cmd_ready_o,
    output reg boost_mode_o,
    output reg xip_mode_o
);
    // Least delays round up, the pause limit rounds down but not below one cycle
    localparam integer SLEEP_CYC = (SLEEP_NS * `SFPIC_CLK_MHZ + 999) / 1000;
    localparam integer WAKE1_CYC = (WAKE1_NS * `SFPIC_CLK_MHZ + 999) / 1000;
    localparam integer WAKE2_CYC = (WAKE2_NS * `SFPIC_CLK_MHZ + 999) / 1000;
    localparam integer PAUSE_RAW = (PAUSE_NS * `SFPIC_CLK_MHZ) / 1000;
    localparam integer PAUSE_CYC = (PAUSE_RAW < 1) ? 32'h0000_0001 : PAUSE_RAW;

    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_CMD = 3'd1;
    localparam [2:0] ST_HOLD = 3'd2;
    localparam [2:0] ST_DUMMY = 3'd3;
    localparam [2:0] ST_OUT = 3'd4;
    localparam [2:0] ST_IGN = 3'd5;

    localparam [1:0] TM_NONE = 2'd0;
    localparam [1:0] TM_SLEEP = 2'd1;
    localparam [1:0] TM_WAKE = 2'd2;
    localparam [1:0] TM_PAUSE = 2'd3;

    // Commands that a paused operation cannot accept
    function pause_blocked;
        input [7:0] code;
        begin
            pause_blocked = (code == `SFPIC_CMD_WRSR) || (code == `SFPIC_CMD_PROG) ||
                (code == `SFPIC_CMD_ERASE_SEC) || (code == `SFPIC_CMD_ERASE_32K) ||
                (code == `SFPIC_CMD_ERASE_64K) || (code == `SFPIC_CMD_ERASE_CH0) ||
                (code == `SFPIC_CMD_ERASE_CH1);
        end
    endfunction

    wire [2:0] pins_s;
    wire cs_s;
    wire sclk_s;
    wire si_s;
    reg cs_p_q;
    reg sclk_p_q;
    reg [2:0] st_q;
    reg [7:0] sh_q;
    reg [2:0] bit_q;
    reg [1:0] byte_q;
    reg [7:0] cmd_q;
    reg addr_hi_zero_q;
    reg [23:0] out_buf_q;
    reg [4:0] out_len_q;
    reg [4:0] ptr_q;
    reg so_q;
    reg [23:0] tmr_q;
    reg [1:0] tmr_mode_q;
    reg paused_q;

    sfpic_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .en_i(en_i),
        .async_i({cs_n_i, sclk_i, si_i}),
        .sync_o(pins_s)
    );

    assign cs_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign si_s = pins_s[0];

    // Edges of the host-made clock and chip select, seen on our own clock
    wire cs_rise = cs_s & ~cs_p_q;
    wire cs_fall = ~cs_s & cs_p_q;
    wire sclk_rise = sclk_s & ~sclk_p_q & ~cs_s;
    wire sclk_fall = ~sclk_s & sclk_p_q & ~cs_s;
    wire byte_done = sclk_rise & (bit_q == 3'd7);
    wire [7:0] new_byte = {sh_q[6:0], si_s};
    // Sleeping, going to sleep or waking: nothing is heard but the wake command once asleep
    wire gated = asleep_o | (tmr_mode_q == TM_SLEEP) | (tmr_mode_q == TM_WAKE);
    wire tmr_expire = (tmr_mode_q != TM_NONE) & (tmr_q == 24'h00_0001);

    assign so_o = so_q;
    assign so_oe_o = (st_q == ST_OUT) & ~cs_s;
    assign cmd_ready_o = ~gated;

    // Edge history
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_p_q <= 1'b1;
            sclk_p_q <= 1'b0;
        end else if (en_i) begin
            cs_p_q <= cs_s;
            sclk_p_q <= sclk_s;
        end
    end

    // Input shift register and bit counter; the counter restarts on every selection
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh_q <= 8'h00;
            bit_q <= 3'd0;
        end else if (en_i) begin
            if (cs_fall) begin
                bit_q <= 3'd0;
            end else if (sclk_rise) begin
                sh_q <= new_byte;
                bit_q <= bit_q + 3'd1;
            end
        end
    end

    // ID output: a new bit on each falling edge, the stream wraps around
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            so_q <= 1'b0;
            ptr_q <= 5'd0;
        end else if (en_i) begin
            if (byte_done && st_q != ST_OUT) begin
                ptr_q <= out_len_d_m1(st_q, cmd_q); // Not mid-stream: the stream must wrap
            end else if (sclk_fall && st_q == ST_OUT) begin
                so_q <= out_buf_q[ptr_q];
                ptr_q <= (ptr_q == 5'd0) ? out_len_q - 5'd1 : ptr_q - 5'd1;
            end
        end
    end

    // Start pointer for whatever stream the finishing byte may open
    function [4:0] out_len_d_m1;
        input [2:0] st;
        input [7:0] cmd;
        begin
            if (st == ST_CMD) begin
                out_len_d_m1 = `SFPIC_LEN24 - 5'd1;
            end else if (cmd == `SFPIC_CMD_MAKER_PART) begin
                out_len_d_m1 = `SFPIC_LEN16 - 5'd1;
            end else begin
                out_len_d_m1 = `SFPIC_LEN8 - 5'd1;
            end
        end
    endfunction

    // Command decode and transaction sequencing
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= ST_IDLE;
            cmd_q <= 8'h00;
            byte_q <= 2'd0;
            addr_hi_zero_q <= 1'b1;
            out_buf_q <= 24'h00_0000;
            out_len_q <= `SFPIC_LEN8;
            cmd_valid_o <= 1'b0;
            cmd_code_o <= 8'h00;
            xip_read_o <= 1'b0;
            op_resume_o <= 1'b0;
            paused_q <= 1'b0;
            boost_mode_o <= 1'b0;
            xip_mode_o <= 1'b0;
            asleep_o <= 1'b0;
            tmr_q <= 24'h00_0000;
            tmr_mode_q <= TM_NONE;
        end else if (en_i) begin
            cmd_valid_o <= 1'b0;
            xip_read_o <= 1'b0;
            op_resume_o <= 1'b0;
            // Shared delay timer
            if (tmr_mode_q != TM_NONE) begin
                tmr_q <= tmr_q - 24'h00_0001;
            end
            if (tmr_expire) begin
                tmr_mode_q <= TM_NONE;
                if (tmr_mode_q == TM_SLEEP) begin
                    asleep_o <= 1'b1;
                end
            end
            if (cs_rise) begin
                // Deselect always returns to standby; ends any ID stream
                st_q <= ST_IDLE;
                // Sleep only on exactly eight bits and no cycle running
                if (st_q == ST_HOLD && bit_q == 3'd0 && cmd_q == `SFPIC_CMD_SLEEP &&
                    !op_active_flag_i && tmr_mode_q == TM_NONE) begin
                    tmr_mode_q <= TM_SLEEP;
                    tmr_q <= SLEEP_CYC[23:0];
                    boost_mode_o <= 1'b0;
                end
                // Bare wake byte from sleep
                if (st_q == ST_DUMMY && cmd_q == `SFPIC_CMD_WAKE_ID && asleep_o &&
                    byte_q == 2'd0 && bit_q == 3'd0) begin
                    asleep_o <= 1'b0;
                    tmr_mode_q <= TM_WAKE;
                    tmr_q <= WAKE1_CYC[23:0];
                end
                // Wake with ID readout from sleep
                if (st_q == ST_OUT && cmd_q == `SFPIC_CMD_WAKE_ID && asleep_o) begin
                    asleep_o <= 1'b0;
                    tmr_mode_q <= TM_WAKE;
                    tmr_q <= WAKE2_CYC[23:0];
                end
            end else if (cs_fall) begin
                byte_q <= 2'd0;
                addr_hi_zero_q <= 1'b1;
                if (xip_mode_o && !gated) begin
                    xip_read_o <= 1'b1;
                end
                st_q <= ST_CMD;
            end else if (sclk_rise) begin
                case (st_q)
                    ST_CMD: begin
                        if (byte_done) begin
                            cmd_q <= new_byte;
                            st_q <= ST_IGN;
                            if (xip_mode_o && !gated) begin
                                // Leading byte of a continuous read is not a command
                                if (new_byte == `SFPIC_CMD_XIP_EXIT) begin
                                    xip_mode_o <= 1'b0;
                                end
                            end else if (gated) begin
                                // Wake only if no self-timed cycle is running
                                if (asleep_o && new_byte == `SFPIC_CMD_WAKE_ID &&
                                    !op_active_flag_i) begin
                                    st_q <= ST_DUMMY;
                                end
                            end else begin
                                case (new_byte)
                                    `SFPIC_CMD_SLEEP: begin
                                        st_q <= ST_HOLD;
                                    end
                                    `SFPIC_CMD_WAKE_ID: begin
                                        if (!op_active_flag_i) begin
                                            st_q <= ST_DUMMY;
                                            boost_mode_o <= 1'b0;
                                        end
                                    end
                                    `SFPIC_CMD_THREE_ID: begin
                                        if (!op_active_flag_i) begin
                                            out_buf_q <= {MFR_ID, MEM_TYPE, MEM_CAP};
                                            out_len_q <= `SFPIC_LEN24;
                                            st_q <= ST_OUT;
                                        end
                                    end
                                    `SFPIC_CMD_MAKER_PART: begin
                                        st_q <= ST_DUMMY;
                                    end
                                    `SFPIC_CMD_BOOST: begin
                                        st_q <= ST_DUMMY;
                                    end
                                    `SFPIC_CMD_PAUSE: begin
                                        // Only a running pausable operation is paused
                                        if (op_active_flag_i && op_pausable_i && !paused_q) begin
                                            paused_q <= 1'b1;
                                            tmr_mode_q <= TM_PAUSE;
                                            tmr_q <= PAUSE_CYC[23:0];
                                        end
                                    end
                                    `SFPIC_CMD_RESUME: begin
                                        if (paused_q) begin
                                            paused_q <= 1'b0;
                                            op_resume_o <= 1'b1;
                                        end
                                    end
                                    `SFPIC_CMD_XIP_EXIT: begin
                                        xip_mode_o <= 1'b0;
                                    end
                                    default: begin
                                        // Other commands go to their own engines
                                        if (!(paused_q && pause_blocked(new_byte))) begin
                                            cmd_valid_o <= 1'b1;
                                            cmd_code_o <= new_byte;
                                        end
                                        if (new_byte == `SFPIC_CMD_WREN) begin
                                            boost_mode_o <= 1'b0;
                                        end
                                    end
                                endcase
                            end
                        end
                    end
                    ST_HOLD: begin
                        // A ninth bit spoils a single-byte command
                        st_q <= ST_IGN;
                    end
                    ST_DUMMY: begin
                        if (byte_done) begin
                            byte_q <= byte_q + 2'd1;
                            if (byte_q != `SFPIC_DUMMY_LAST) begin
                                if (new_byte != 8'h00) begin
                                    addr_hi_zero_q <= 1'b0;
                                end
                            end else begin
                                // Third byte: dummies are not looked at
                                st_q <= ST_IGN;
                                if (cmd_q == `SFPIC_CMD_WAKE_ID) begin
                                    out_buf_q <= {16'h0000, DEV_ID};
                                    out_len_q <= `SFPIC_LEN8;
                                    st_q <= ST_OUT;
                                end else if (cmd_q == `SFPIC_CMD_BOOST) begin
                                    boost_mode_o <= 1'b1;
                                end else if (addr_hi_zero_q && new_byte == 8'h00) begin
                                    out_buf_q <= {8'h00, MFR_ID, DEV_ID};
                                    out_len_q <= `SFPIC_LEN16;
                                    st_q <= ST_OUT;
                                end else if (addr_hi_zero_q &&
                                    new_byte == `SFPIC_ADDR_DEV_FIRST) begin
                                    out_buf_q <= {8'h00, DEV_ID, MFR_ID};
                                    out_len_q <= `SFPIC_LEN16;
                                    st_q <= ST_OUT;
                                end
                            end
                        end
                    end
                    ST_OUT: begin
                        st_q <= ST_OUT;
                    end
                    ST_IGN: begin
                        st_q <= ST_IGN;
                    end
                    default: begin
                        st_q <= ST_IDLE;
                    end
                endcase
            end
            // Mode bits from the fast read engine; last, so a new setting beats an exit
            if (cont_bits_valid_i) begin
                xip_mode_o <= (continuous_mode_bits_i[7:4] == `SFPIC_XIP_NIB);
            end
        end
    end

    // Busy: 1 while pausing, hidden while paused, engine flag otherwise
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_o <= 1'b0;
            op_pause_o <= 1'b0;
        end else if (en_i) begin
            busy_o <= (tmr_mode_q == TM_PAUSE && !tmr_expire) ||
                (op_active_flag_i && !paused_q);
            op_pause_o <= paused_q;
        end
    end
endmodule // sfpic_core

// ==== design/sfpic_sync.v ====
`include "sfpic_defs.vh"

// Two-stage synchroniser for the three link pins
module sfpic_sync (
    input wire clk_i,
    input wire rst_n_i,
    input wire en_i,
    input wire [2:0] async_i,
    output wire [2:0] sync_o
);
    reg [2:0] meta_q;
    reg [2:0] stab_q;

    // First stage feeds only the second stage
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Idle levels, so no false clock edge follows reset
            meta_q <= `SFPIC_PIN_IDLE;
            stab_q <= `SFPIC_PIN_IDLE;
        end else if (en_i) begin
            meta_q <= async_i;
            stab_q <= meta_q;
        end
    end

    assign sync_o = stab_q;
endmodule // sfpic_sync

// ==== verif/sfpic_core_monitor.sv ====
module sfpic_core_monitor (
    input wire clk_i,
    input wire rst_n_i,
    input wire en_i,
    input wire cs_n_i,
    input wire op_pausable_i,
    input wire cont_bits_valid_i,
    input wire [7:0] continuous_mode_bits_i,
    input wire so_oe_o,
    input wire cmd_valid_o,
    input wire [7:0] cmd_code_o,
    input wire xip_read_o,
    input wire op_pause_o,
    input wire op_resume_o,
    input wire asleep_o,
    input wire cmd_ready_o,
    input wire boost_mode_o,
    input wire xip_mode_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Single domain, so clock and reset are stated once
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_sleep_gate; asleep_o |-> !cmd_ready_o && !cmd_valid_o; endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("command taken while asleep");
    property p_sleep_entry; $rose(asleep_o) |-> !$past(cmd_ready_o) && cs_n_i; endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep without entry delay");
    property p_sleep_boost; $rose(asleep_o) |-> !boost_mode_o; endproperty
    a_sleep_boost: assert property (p_sleep_boost) else $error("boost kept into sleep");
    // Sync takes two cycles, so four idle cycles leave margin
    property p_oe_end; cs_n_i [*4] |-> !so_oe_o; endproperty
    a_oe_end: assert property (p_oe_end) else $error("output enabled while deselected");
    property p_xip_set;
        en_i && cont_bits_valid_i && continuous_mode_bits_i[7:4] == 4'hA |-> ##[1:2] xip_mode_o;
    endproperty
    a_xip_set: assert property (p_xip_set) else $error("mode bits did not arm");
    property p_xip_read; xip_read_o |-> xip_mode_o; endproperty
    a_xip_read: assert property (p_xip_read) else $error("repeat read outside mode");
    property p_pause_src; $rose(op_pause_o) |-> $past(op_pausable_i); endproperty
    a_pause_src: assert property (p_pause_src) else $error("pause of a plain cycle");
    property p_resume_src; op_resume_o |-> $past(op_pause_o); endproperty
    a_resume_src: assert property (p_resume_src) else $error("resume without pause");
    property p_paused_refuse;
        cmd_valid_o && op_pause_o |-> !(cmd_code_o inside {8'h01, 8'h02, 8'h20, 8'h52,
            8'hD8, 8'hC7, 8'h60});
    endproperty
    a_paused_refuse: assert property (p_paused_refuse) else $error("write passed in pause");
endmodule // sfpic_core_monitor

bind sfpic_core sfpic_core_monitor sfpic_core_monitor_i (.clk_i, .rst_n_i, .en_i, .cs_n_i,
    .op_pausable_i, .cont_bits_valid_i, .continuous_mode_bits_i, .so_oe_o, .cmd_valid_o,
    .cmd_code_o, .xip_read_o, .op_pause_o, .op_resume_o, .asleep_o, .cmd_ready_o,
    .boost_mode_o, .xip_mode_o);

// ==== verif/sfpic_core_tb.sv ====
`include "sfpic_defs.vh"
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module sfpic_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_n_i = 1'b0, en_i = 1'b1, act = 1'b0, pausable = 1'b0, cbv = 1'b0;
    logic [7:0] cbits = 8'h00;
    logic [7:0] last_code = 8'h00;
    logic [63:0] rx;
    logic [7:0] refused [7] = '{8'h01, 8'h02, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
    wire cs_n, sclk, si, so, so_oe, cmd_valid, xip_read, op_pause, op_resume;
    wire busy, asleep, ready, boost, xip;
    wire [7:0] cmd_code;
    int failures = 0, checked = 0, n_cmd = 0, n_xr = 0, n_res = 0, n_oe = 0, k;
    always #2 clk_i = ~clk_i;
    // Short delays keep the sleep and wake waits inside the host gap
    sfpic_core #(.SLEEP_NS(20), .WAKE1_NS(20), .WAKE2_NS(20), .PAUSE_NS(20)) sfpic_core_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .si_i(si), .so_o(so), .so_oe_o(so_oe), .op_active_flag_i(act),
        .op_pausable_i(pausable), .cont_bits_valid_i(cbv), .continuous_mode_bits_i(cbits),
        .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .xip_read_o(xip_read),
        .op_pause_o(op_pause), .op_resume_o(op_resume), .busy_o(busy), .asleep_o(asleep),
        .cmd_ready_o(ready), .boost_mode_o(boost), .xip_mode_o(xip));
    // Released output line shows the inverse, so stale data cannot pass
    sfpic_host_model sfpic_host_model_i (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si),
        .so_i(so_oe ? so : ~so));
    // One-cycle pulses and output-enable cycles are tallied here, the scenarios read the tallies
    always @(posedge clk_i) begin
        if (cmd_valid === 1'b1) n_cmd++;
        if (cmd_valid === 1'b1) last_code = cmd_code;
        if (xip_read === 1'b1) n_xr++;
        if (op_resume === 1'b1) n_res++;
        if (so_oe === 1'b1) n_oe++;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic send(input int n, input logic [63:0] d);
        sfpic_host_model_i.frame(n, d, rx);
    endtask
    task automatic final_report();
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_ident();
        send(40, {8'h9F, 32'h0});
        `CHK("id3", {`SFPIC_MFR_ID, `SFPIC_MEM_TYPE, `SFPIC_MEM_CAP, `SFPIC_MFR_ID}, rx[31:0])
        `CHK("oe_off", 1'b0, so_oe)
        `CHK("standby", 1'b0, asleep)
        send(48, {8'h90, 24'h0, 16'h0});
        `CHK("mfr_dev", {`SFPIC_MFR_ID, `SFPIC_DEV_ID}, rx[15:0])
        send(48, {8'h90, 24'h1, 16'h0});
        `CHK("dev_mfr", {`SFPIC_DEV_ID, `SFPIC_MFR_ID}, rx[15:0])
        send(48, {8'hAB, 24'hC3_5A96, 16'h0});
        `CHK("dev_id", {`SFPIC_DEV_ID, `SFPIC_DEV_ID}, rx[15:0])
    endtask
    task automatic t_boost();
        send(32, {8'hA3, 24'hFF_FFFF});
        `CHK("boost_on", 1'b1, boost)
        send(8, 8'h06);
        `CHK("boost_wren", 1'b0, boost)
        `CHK("wren_fwd", 8'h06, last_code)
        send(32, {8'hA3, 24'h0});
        send(8, 8'hAB);
        `CHK("boost_wake", 1'b0, boost)
    endtask
    task automatic t_sleep();
        // Stray bit after the code, then a short code: both must not sleep
        send(9, 9'h172);
        send(7, 7'h5C);
        `CHK("sleep_len", 1'b0, asleep)
        send(32, {8'hA3, 24'h0});
        send(8, 8'hB9);
        `CHK("asleep", 1'b1, asleep)
        `CHK("boost_sleep", 1'b0, boost)
        k = n_cmd;
        send(8, 8'h06);
        send(32, {8'h02, 24'h0});
        `CHK("sleep_deaf", k, n_cmd)
        send(8, 8'hAB);
        `CHK("awake", 1'b0, asleep)
        `CHK("ready", 1'b1, ready)
        send(8, 8'hB9);
        send(40, {8'hAB, 32'h0});
        `CHK("wake_id", `SFPIC_DEV_ID, rx[7:0])
        `CHK("awake_id", 1'b0, asleep)
    endtask
    task automatic t_busy();
        @(posedge clk_i);
        act <= 1'b1;
        send(8, 8'hB9);
        `CHK("sleep_rej", 1'b0, asleep)
        k = n_oe;
        send(40, {8'hAB, 32'h0});
        send(32, {8'h9F, 24'h0});
        `CHK("id_rej", k, n_oe)
        send(8, 8'h75);
        `CHK("plain_nopause", 1'b0, op_pause)
        @(posedge clk_i);
        pausable <= 1'b1;
        send(8, 8'h75);
        `CHK("paused", 1'b1, op_pause)
        `CHK("busy_clr", 1'b0, busy)
        k = n_cmd;
        foreach (refused[i]) send(8, refused[i]);
        `CHK("pause_refuse", k, n_cmd)
        send(32, {8'h03, 24'h0});
        `CHK("pause_read", k + 1, n_cmd)
        send(8, 8'h7A);
        `CHK("resumed", 1, n_res)
        `CHK("busy_resume", 1'b1, busy)
        send(8, 8'h7A);
        `CHK("resume_once", 1, n_res)
        @(posedge clk_i);
        act <= 1'b0;
        pausable <= 1'b0;
    endtask
    task automatic t_xip();
        // Clock enable low: mode bits offered then must not arm
        @(posedge clk_i);
        en_i <= 1'b0;
        cbits <= 8'hA5;
        cbv <= 1'b1;
        @(posedge clk_i);
        en_i <= 1'b1;
        cbv <= 1'b0;
        cyc(2);
        `CHK("frozen", 1'b0, xip)
        @(posedge clk_i);
        cbits <= 8'h5A;
        cbv <= 1'b1;
        @(posedge clk_i);
        cbits <= 8'hA5;
        @(posedge clk_i);
        cbv <= 1'b0;
        cyc(3);
        `CHK("xip_on", 1'b1, xip)
        k = n_oe;
        send(32, {8'h9F, 24'h0});
        `CHK("xip_read", 1, n_xr)
        `CHK("xip_deaf", k, n_oe)
        send(8, 8'hFF);
        `CHK("xip_off", 1'b0, xip)
        send(32, {8'h9F, 24'h0});
        `CHK("id_again", 1'b1, n_oe > k)
    endtask
    initial begin
        cyc(6);
        rst_n_i <= 1'b1;
        cyc(2);
        t_ident();
        t_boost();
        t_sleep();
        t_busy();
        t_xip();
        final_report();
    end
    // Watchdog against a hung frame or a stuck design
    initial begin
        cyc(90000);
        failures++;
        final_report();
    end
endmodule // sfpic_core_tb

// ==== verif/sfpic_host_model.sv ====
module sfpic_host_model (
    output logic cs_n_o,
    output logic sclk_o,
    output logic si_o,
    input wire so_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Mode 0 host; serial clock rests low outside frames
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end
    // Whole frame at 125 ns per bit, phase unrelated to the system clock
    task automatic frame(input int n, input logic [63:0] dout, output logic [63:0] din);
        din = '0;
        #1.3 cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            si_o = dout[n-1-i];
            #62.5 sclk_o = 1'b1;
            din = {din[62:0], so_i};
            #62.5 sclk_o = 1'b0;
        end
        #20 cs_n_o = 1'b1;
        si_o = ~si_o;
        // Deselect gap outlasts every wake delay before the next frame
        #200;
    endtask
endmodule // sfpic_host_model
